// ---- hw/addr_fifo.sv ----
// no logic of its own: the address fifo module sits beside the address generator

// ---- hw/dma_channel_address_gen.sv ----
`timescale 1ns/100ps
// per-channel base and offset registers with byte address generation
module dma_channel_address_gen #(
    parameter int NUM_CHAN = 8,
    parameter int SEL_W = 3,
    parameter int DEPTH = chan_addr_pkg::FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // special-function-register bus
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // channel chosen by the channel select register elsewhere
    input wire logic [SEL_W-1:0] i_chan_sel,
    // byte moved on a channel; stalls while the address fifo is full
    input wire logic i_byte_move,
    input wire logic [SEL_W-1:0] i_move_chan,
    output logic o_move_ready,
    // size match and wrap control from the length logic
    input wire logic [NUM_CHAN-1:0] i_size_match,
    input wire logic [NUM_CHAN-1:0] i_wrap_en,
    output logic [NUM_CHAN-1:0] o_full_len,
    // data ram address stream
    output logic o_ram_valid,
    input wire logic i_ram_ready,
    output logic [chan_addr_pkg::BASE_W-1:0] o_ram_addr
);
    localparam int BW = chan_addr_pkg::BASE_W;
    localparam int OW = chan_addr_pkg::OFFS_W;

    // per-channel base and offset state
    logic [BW-1:0] base_ff [NUM_CHAN];
    logic [BW-1:0] nxt_base [NUM_CHAN];
    logic [OW-1:0] offs_ff [NUM_CHAN];
    logic [OW-1:0] nxt_offs [NUM_CHAN];
    logic [NUM_CHAN-1:0] full_ff, nxt_full;
    logic [7:0] rdata_ff, nxt_rdata;
    // address computed for the moving channel
    logic [BW-1:0] move_addr;
    logic move_fire;
    logic fifo_ready;

    // a byte is only taken when the fifo can hold its address
    assign o_move_ready = fifo_ready;
    assign move_fire = i_byte_move & fifo_ready;
    // base plus offset, offset zero yields the base itself
    assign move_addr = base_ff[i_move_chan] + BW'(offs_ff[i_move_chan]);

    // next values for base, offset, full flags and read data
    always_comb begin
        nxt_rdata = chan_addr_pkg::RDATA_RST;
        nxt_full = full_ff;
        for (int c = 0; c < NUM_CHAN; c++) begin
            nxt_base[c] = base_ff[c];
            nxt_offs[c] = offs_ff[c];
            // size match on any channel raises full length
            if (i_size_match[c]) begin
                nxt_full[c] = 1'b1;
                // wrap restarts the offset at zero
                if (i_wrap_en[c]) begin
                    nxt_offs[c] = chan_addr_pkg::OFFS_RST;
                end
            end
        end
        // byte moved: one 10-bit increment with carry into high bits
        if (move_fire && !(i_size_match[i_move_chan] && i_wrap_en[i_move_chan])) begin
            nxt_offs[i_move_chan] = offs_ff[i_move_chan] + 1'b1;
        end
        // software writes go to the selected channel only
        if (i_sfr_wr) begin
            case (i_sfr_addr)
                chan_addr_pkg::OFS_BASE_LO: begin
                    nxt_base[i_chan_sel][7:0] = i_sfr_wdata;
                end
                chan_addr_pkg::OFS_BASE_HI: begin
                    // upper bits discarded
                    nxt_base[i_chan_sel][BW-1:8] = i_sfr_wdata[chan_addr_pkg::BASE_HI_W-1:0];
                end
                chan_addr_pkg::OFS_OFFS_LO: begin
                    nxt_offs[i_chan_sel][7:0] = i_sfr_wdata;
                    nxt_full[i_chan_sel] = i_size_match[i_chan_sel];
                end
                chan_addr_pkg::OFS_OFFS_HI: begin
                    // upper bits discarded
                    nxt_offs[i_chan_sel][OW-1:8] = i_sfr_wdata[chan_addr_pkg::OFFS_HI_W-1:0];
                    nxt_full[i_chan_sel] = i_size_match[i_chan_sel];
                end
                default: begin
                end
            endcase
        end
        // read mux for the selected channel, unused bits zero
        case (i_sfr_addr)
            chan_addr_pkg::OFS_BASE_LO: nxt_rdata = nxt_base[i_chan_sel][7:0];
            chan_addr_pkg::OFS_BASE_HI: nxt_rdata = {4'h0, nxt_base[i_chan_sel][BW-1:8]};
            chan_addr_pkg::OFS_OFFS_LO: nxt_rdata = nxt_offs[i_chan_sel][7:0];
            chan_addr_pkg::OFS_OFFS_HI: nxt_rdata = {6'h00, nxt_offs[i_chan_sel][OW-1:8]};
            default: nxt_rdata = chan_addr_pkg::RDATA_RST;
        endcase
    end

    // registers, all cleared on reset
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                base_ff[c] <= chan_addr_pkg::BASE_RST;
                offs_ff[c] <= chan_addr_pkg::OFFS_RST;
            end
            full_ff <= '0;
            rdata_ff <= chan_addr_pkg::RDATA_RST;
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                base_ff[c] <= nxt_base[c];
                offs_ff[c] <= nxt_offs[c];
            end
            full_ff <= nxt_full;
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_sfr_rdata = rdata_ff;
    assign o_full_len = full_ff;

    // fifo carrying the generated addresses to the ram side
    addr_fifo #(
        .WIDTH(BW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_byte_move),
        .o_in_ready(fifo_ready),
        .i_in_data(move_addr),
        .o_out_valid(o_ram_valid),
        .i_out_ready(i_ram_ready),
        .o_out_data(o_ram_addr)
    );

    // increment by exactly one per accepted byte
    a_offs_incr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (move_fire && !i_sfr_wr && !i_size_match[i_move_chan])
        |=> offs_ff[$past(i_move_chan)] == $past(offs_ff[i_move_chan]) + 10'h001)
        else $error("offset did not step by one");
    // zero offset yields the base
    a_zero_base: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (offs_ff[i_move_chan] == 10'h000) |-> move_addr == base_ff[i_move_chan])
        else $error("address differs from base at zero offset");
    // base high readback upper nibble zero
    a_base_hi_rd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        ($past(i_sfr_addr) == chan_addr_pkg::OFS_BASE_HI) |-> o_sfr_rdata[7:4] == 4'h0)
        else $error("base high unused bits not zero");
    // offset high readback upper bits zero
    a_offs_hi_rd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        ($past(i_sfr_addr) == chan_addr_pkg::OFS_OFFS_HI) |-> o_sfr_rdata[7:2] == 6'h00)
        else $error("offset high unused bits not zero");
    // low base write lands in the selected channel
    a_base_wr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_sfr_wr && i_sfr_addr == chan_addr_pkg::OFS_BASE_LO)
        |=> base_ff[$past(i_chan_sel)][7:0] == $past(i_sfr_wdata))
        else $error("base low write lost");
    // offset low write lands in the selected channel
    a_offs_wr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_sfr_wr && i_sfr_addr == chan_addr_pkg::OFS_OFFS_LO)
        |=> offs_ff[$past(i_chan_sel)][7:0] == $past(i_sfr_wdata))
        else $error("offset low write lost");
    // size match sets the full flag next cycle
    a_full_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_size_match[0] && !i_sfr_wr) |=> o_full_len[0])
        else $error("full length flag not raised");
    // wrap returns the offset to zero
    a_wrap_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_size_match[0] && i_wrap_en[0] && !i_sfr_wr) |=> offs_ff[0] == 10'h000)
        else $error("wrap did not clear offset");
    // carry from the low byte reaches the high bits
    a_carry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (move_fire && !i_sfr_wr && !i_size_match[i_move_chan]
         && offs_ff[i_move_chan][7:0] == 8'hff && offs_ff[i_move_chan][9:8] != 2'h3)
        |=> offs_ff[$past(i_move_chan)][9:8] == $past(offs_ff[i_move_chan][9:8]) + 2'h1)
        else $error("carry lost into high offset bits");
    // reset leaves the read data cleared
    a_rst_clear: assert property (@(posedge i_ref_clk)
        $rose(i_rst_b) |-> o_sfr_rdata == 8'h00 && o_full_len == '0)
        else $error("state not cleared by reset");
    // a refused byte leaves the offset where it was
    a_move_refused: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_byte_move && !o_move_ready && !i_sfr_wr && !i_size_match[i_move_chan])
        |=> offs_ff[$past(i_move_chan)] == $past(offs_ff[i_move_chan]))
        else $error("refused byte moved the offset");
    // high base write keeps only the implemented nibble
    a_base_hi_wr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_sfr_wr && i_sfr_addr == chan_addr_pkg::OFS_BASE_HI)
        |=> base_ff[$past(i_chan_sel)][BW-1:8] == $past(i_sfr_wdata[3:0]))
        else $error("base high write lost");
    // high offset write keeps only the implemented two bits
    a_offs_hi_wr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_sfr_wr && i_sfr_addr == chan_addr_pkg::OFS_OFFS_HI)
        |=> offs_ff[$past(i_chan_sel)][OW-1:8] == $past(i_sfr_wdata[1:0]))
        else $error("offset high write lost");
    // a write to another channel leaves channel zero untouched
    a_unsel_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_sfr_wr && i_chan_sel != '0)
        |=> base_ff[0] == $past(base_ff[0]))
        else $error("unselected channel base changed");
    // the full flag stays up until software rewrites the offset
    a_full_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_full_len[0] && !i_sfr_wr) |=> o_full_len[0])
        else $error("full length flag dropped on its own");
    // reset leaves base and offset of the selected channel cleared
    a_rst_regs: assert property (@(posedge i_ref_clk)
        $rose(i_rst_b) |-> base_ff[i_chan_sel] == chan_addr_pkg::BASE_RST
        && offs_ff[i_chan_sel] == chan_addr_pkg::OFFS_RST)
        else $error("base or offset not cleared by reset");
endmodule : dma_channel_address_gen

// small valid/ready fifo of parameterised width and depth
module addr_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    // storage array and its next contents
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr;
    logic [AW-1:0] rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // full and empty from the fill count, compared at the count's own width
    assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data = mem_ff[rd_ff];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    // pointer and count update
    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    // pointer registers
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // next storage contents: only the write slot changes on a push
    always_comb begin
        nxt_mem = mem_ff;
        if (push) begin
            nxt_mem[wr_ff] = i_in_data;
        end
    end

    // data storage, no reset needed since empty slots are never shown as valid
    always_ff @(posedge i_ref_clk) begin
        mem_ff <= nxt_mem;
    end

    // the fill count never passes the depth
    a_fill_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        cnt_ff <= (AW+1)'(DEPTH))
        else $error("fifo fill count above depth");
    // a stalled head holds its value
    a_head_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_out_valid && !i_out_ready) |=> (o_out_valid && $stable(o_out_data)))
        else $error("fifo head changed while stalled");
endmodule : addr_fifo

// ---- inc/chan_addr_pkg.sv ----
// shared constants for the per-channel address generator
package chan_addr_pkg;
    // register offsets on the special-function-register bus
    localparam logic [7:0] OFS_BASE_LO = 8'hca;
    localparam logic [7:0] OFS_BASE_HI = 8'hcb;
    localparam logic [7:0] OFS_OFFS_LO = 8'hcc;
    localparam logic [7:0] OFS_OFFS_HI = 8'hcd;
    // field widths
    localparam int BASE_HI_W = 4;
    localparam int OFFS_HI_W = 2;
    localparam int BASE_W = 12;
    localparam int OFFS_W = 10;
    // values after reset
    localparam logic [BASE_W-1:0] BASE_RST = 12'h000;
    localparam logic [OFFS_W-1:0] OFFS_RST = 10'h000;
    localparam logic [7:0] RDATA_RST = 8'h00;
    // default fifo depth
    localparam int FIFO_DEPTH = 8;
endpackage : chan_addr_pkg

// ---- verification/ram_sink.sv ----
`timescale 1ns/100ps
// data ram model that takes the address stream and stalls on command
module ram_sink (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_stall,
    input wire logic i_ram_valid,
    input wire logic [chan_addr_pkg::BASE_W-1:0] i_ram_addr,
    output logic o_ram_ready
);
    // addresses taken, oldest first
    logic [chan_addr_pkg::BASE_W-1:0] seen_q[$];
    // ready only follows the stall command, so a slow ram is easy to mimic
    assign o_ram_ready = ~i_stall;
    // take one address at each edge where valid meets ready
    always @(posedge i_ref_clk) begin
        if (i_rst_b && i_ram_valid && o_ram_ready) begin
            seen_q.push_back(i_ram_addr);
        end
    end
endmodule : ram_sink

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
// self-checking bench for the per-channel address generator
module testbench;
    logic clk, rst_b, sfr_wr, byte_move, move_ready, ram_valid, ram_ready, stall;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, size_match, wrap_en, full_len;
    logic [2:0] chan_sel, move_chan;
    logic [11:0] ram_addr;
    int miscompares = 0;
    int total_checks = 0;
    // design under test with its default counts
    dma_channel_address_gen uut (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr), .i_sfr_wdata(sfr_wdata),
        .o_sfr_rdata(sfr_rdata), .i_chan_sel(chan_sel), .i_byte_move(byte_move),
        .i_move_chan(move_chan), .o_move_ready(move_ready), .i_size_match(size_match),
        .i_wrap_en(wrap_en), .o_full_len(full_len), .o_ram_valid(ram_valid),
        .i_ram_ready(ram_ready), .o_ram_addr(ram_addr));
    // far side of the address stream
    ram_sink sink (.i_ref_clk(clk), .i_rst_b(rst_b), .i_stall(stall),
        .i_ram_valid(ram_valid), .i_ram_addr(ram_addr), .o_ram_ready(ram_ready));
    // free-running clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // compare one value and count it
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one register write pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr
    // present an address, check the read data one cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = a;
        @(negedge clk);
        chk($sformatf("reg %h", a), {4'h0, exp}, {4'h0, sfr_rdata});
    endtask : rd
    // n back-to-back byte moves on one channel
    task automatic mv(input logic [2:0] ch, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            byte_move = 1'b1;
            move_chan = ch;
        end
        @(negedge clk);
        byte_move = 1'b0;
    endtask : mv
    // every register of a channel reads zero after reset
    task automatic t_reset;
        chan_sel = 3'h0;
        for (int a = 8'hca; a <= 8'hcd; a++) rd(a[7:0], 8'h00);
    endtask : t_reset
    // field widths, unused bits, channel routing, unmapped address
    task automatic t_regs;
        chan_sel = 3'h2;
        for (int a = 8'hca; a <= 8'hcd; a++) wr(a[7:0], 8'hff);
        wr(8'hca, 8'h12);
        rd(8'hca, 8'h12);
        rd(8'hcb, 8'h0f);
        rd(8'hcc, 8'hff);
        rd(8'hcd, 8'h03);
        chan_sel = 3'h3;
        rd(8'hca, 8'h00);
        rd(8'hcd, 8'h00);
        wr(8'hc0, 8'h55);
        rd(8'hc0, 8'h00);
    endtask : t_regs
    // fill the fifo against a stalled ram, then drain it
    task automatic t_fill;
        chan_sel = 3'h1;
        stall = 1'b1;
        wr(8'hca, 8'hfe);
        wr(8'hcb, 8'h01);
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        mv(3'h1, 9);
        chk("move_ready", 12'h0, {11'h0, move_ready});
        rd(8'hcc, 8'h08);
        stall = 1'b0;
        repeat (12) @(negedge clk);
        chk("drained", 12'h8, 12'(sink.seen_q.size()));
        for (int i = 0; i < 8; i++) chk("ram addr", 12'h1fe + 12'(i), sink.seen_q[i]);
        chk("ram_valid", 12'h0, {11'h0, ram_valid});
    endtask : t_fill
    // carry from the low offset byte into the high bits
    task automatic t_carry;
        chan_sel = 3'h4;
        wr(8'hcc, 8'hff);
        mv(3'h4, 1);
        repeat (3) @(negedge clk);
        rd(8'hcd, 8'h01);
        rd(8'hcc, 8'h00);
        chk("carry addr", 12'h0ff, sink.seen_q[$]);
    endtask : t_carry
    // size match flags full length, wrap clears the offset
    task automatic t_wrap;
        chan_sel = 3'h0;
        mv(3'h0, 3);
        size_match = 8'h01;
        wrap_en = 8'h01;
        @(negedge clk);
        size_match = 8'h00;
        wrap_en = 8'h00;
        chk("full_len", 12'h001, {4'h0, full_len});
        rd(8'hcc, 8'h00);
        wr(8'hcc, 8'h00);
        chk("full_clear", 12'h000, {4'h0, full_len});
    endtask : t_wrap
    // print counts and verdict, then stop
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    // watchdog well past the expected run length
    initial begin
        #40000;
        miscompares++;
        test_done;
    end
    // main sequence
    initial begin
        {sfr_wr, byte_move, stall} = 3'b000;
        {sfr_addr, sfr_wdata, size_match, wrap_en} = 32'h0;
        {chan_sel, move_chan} = 6'h0;
        rst_b = 1'b0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        t_reset;
        t_regs;
        t_fill;
        t_carry;
        t_wrap;
        test_done;
    end
endmodule : testbench
